// ### verilog/tmr_chan.sv
// one-shot and pwm timer channel with register port and interrupt
// assumes a single-cycle register master on sys_clk and an overflow
// pulse from another timer that is already on sys_clk
// registers by word address: 0 ctrl, 1 mode, 2 timer, 3 status, 4 mask, 5 port
// unmapped addresses read as zero and ignore writes
//
// Notes on behaviour
// - one-shot counts down, reloads at zero, halts
// - one-shot retrigger while running reloads and restarts
// - one-shot active for n count-source cycles
// - one-shot starts on pin, overflow or flag
// - clearing count start stops counting at once
// - one-shot interrupt when count reaches zero
// - trigger pin is port or trigger input
// - output pin is port or pulse in one-shot, pulse only in pwm
// - timer register reads return undefined value
// - write while stopped loads reload and counter
// - write while running loads reload only
// - pwm selectable as 16-bit or 8-bit
// - pwm reloads at each rising edge, keeps counting
// - pwm ignores triggers while counting
// - pwm16 high n cycles, period 65535
// - pwm8 high n(m+1), period 255(m+1)
// - pwm starts on pin, overflow or flag
// - pwm interrupt at each falling edge
`timescale 1ns/1ps
`default_nettype none
module tmr_chan (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        timer_trigger_in,
  input  wire logic        other_timer_ovf,
  output logic             timer_pulse_out,
  output logic             irq
);

  typedef struct packed {
    tmr_pkg::tmr_state_t state;
    tmr_pkg::tmr_cfg_t   cfg;
    logic                start;
    logic [15:0]         reload;
    logic [15:0]         cnt;
    // steps left in the current pwm period
    logic [15:0]         per;
    // 8-bit pwm: count-source cycles already spent in this step
    logic [7:0]          sub;
    // divider that makes the count source from sys_clk
    logic [4:0]          pre;
    // pulse level before the pin multiplexer
    logic                pulse;
    logic                port_val;
    logic [0:0]          status;
    logic [0:0]          mask;
    logic [15:0]         rdata;
    logic                pin;
    logic                irq;
  } tmr_st_t;

  tmr_st_t st_ff;
  tmr_st_t nxt_st;

  logic trig_lvl;
  logic trig_rise;
  logic trig_fall;

  tmr_sync u_trig_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .din     (timer_trigger_in),
    .level   (trig_lvl),
    .rise    (trig_rise),
    .fall    (trig_fall)
  );

  // terminal count of the prescaler for the selected count source
  function automatic logic [4:0] div_tc(input tmr_pkg::tmr_clk_t sel);
    logic [4:0] tc;
    tc = tmr_pkg::DIV1_TC;
    unique case (sel)
      tmr_pkg::TMR_CLK_F1:  tc = tmr_pkg::DIV1_TC;
      tmr_pkg::TMR_CLK_F8:  tc = tmr_pkg::DIV8_TC;
      tmr_pkg::TMR_CLK_F32: tc = tmr_pkg::DIV32_TC;
      tmr_pkg::TMR_CLK_RSV: tc = tmr_pkg::DIV32_TC;
    endcase
    return tc;
  endfunction

  // high time of a pwm period: full word in 16-bit, high byte in 8-bit
  function automatic logic [15:0] pwm_high(input logic pwm8, input logic [15:0] rl);
    return pwm8 ? {8'h00, rl[15:8]} : rl;
  endfunction

  // a register is selected when its strobe is up beside its word address
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [3:0] addr,
                                   input logic [3:0] ofs);
    return strobe && addr == ofs;
  endfunction

  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_timer;
  logic        wr_mask;
  logic        wr_port;
  logic        rd_status;
  logic        tick;
  logic        step;
  logic        hw_start;
  logic        sw_start;
  logic        start_ev;
  logic        event_set;
  logic        start_now;
  logic [15:0] hi_val;
  logic [15:0] start_val;

  always_comb begin
    wr_ctrl   = reg_hit(reg_wr, reg_addr, tmr_pkg::OFS_CTRL);
    wr_mode   = reg_hit(reg_wr, reg_addr, tmr_pkg::OFS_MODE);
    wr_timer  = reg_hit(reg_wr, reg_addr, tmr_pkg::OFS_TIMER);
    wr_mask   = reg_hit(reg_wr, reg_addr, tmr_pkg::OFS_MASK);
    wr_port   = reg_hit(reg_wr, reg_addr, tmr_pkg::OFS_PORT);
    rd_status = reg_hit(reg_rd, reg_addr, tmr_pkg::OFS_STATUS);
    // with f1 the terminal count is zero, so a started counter ticks every cycle
    tick      = st_ff.start && st_ff.pre == div_tc(st_ff.cfg.clk);
    // in 8-bit pwm the low byte stretches each step to m+1 count-source cycles
    if (st_ff.cfg.mode == tmr_pkg::TMR_PWM && st_ff.cfg.pwm8) begin
      step = tick && st_ff.sub == st_ff.reload[7:0];
    end else begin
      step = tick;
    end
    hi_val = pwm_high(st_ff.cfg.pwm8, st_ff.reload);
    // a start takes a timer value written beside it, bypassing the reload register
    start_val = wr_timer ? reg_wdata : st_ff.reload;
  end

  // start sources; the pin only counts once it is configured as trigger input
  always_comb begin
    hw_start = 1'b0;
    unique case (st_ff.cfg.trig)
      tmr_pkg::TMR_TRIG_SW:   hw_start = 1'b0;
      tmr_pkg::TMR_TRIG_FALL: hw_start = trig_fall;
      tmr_pkg::TMR_TRIG_RISE: hw_start = trig_rise;
      // the overflow pulse is already on sys_clk and needs no synchroniser
      tmr_pkg::TMR_TRIG_OVF:  hw_start = other_timer_ovf;
    endcase
    sw_start = 1'b0;
    if (st_ff.cfg.mode == tmr_pkg::TMR_ONESHOT) begin
      // the write that sets the count start flag may fire the shot as well
      sw_start = wr_ctrl && reg_wdata[tmr_pkg::CTRL_OSSTART]
                 && reg_wdata[tmr_pkg::CTRL_START];
    end else if (st_ff.cfg.trig == tmr_pkg::TMR_TRIG_SW) begin
      // software-only pwm starts as soon as the count start flag is up
      sw_start = st_ff.start && st_ff.state == tmr_pkg::TMR_IDLE;
    end
    start_ev = (st_ff.start && hw_start) || sw_start;
  end

  always_comb begin
    nxt_st    = st_ff;
    event_set = 1'b0;
    start_now = 1'b0;

    // mode changes are refused while running so the pin never sees a half-switched mode
    if (wr_mode && st_ff.state == tmr_pkg::TMR_IDLE) begin
      nxt_st.cfg = tmr_pkg::tmr_cfg_t'(reg_wdata[tmr_pkg::CFG_W-1:0]);
    end
    if (wr_mask) begin
      nxt_st.mask = reg_wdata[tmr_pkg::ST_EVENT];
    end
    if (wr_port) begin
      nxt_st.port_val = reg_wdata[tmr_pkg::PORT_OUT_VAL];
    end
    if (wr_ctrl) begin
      nxt_st.start = reg_wdata[tmr_pkg::CTRL_START];
    end

    // prescaler runs only while the count start flag is set
    if (!st_ff.start || tick) begin
      nxt_st.pre = 5'h00;
    end else begin
      nxt_st.pre = st_ff.pre + 5'h01;
    end
    if (!st_ff.start || step) begin
      nxt_st.sub = 8'h00;
    end else if (tick) begin
      nxt_st.sub = st_ff.sub + 8'h01;
    end

    // a running count keeps going; the new reload waits for the next reload point, but its low byte sets the 8-bit pwm step at once
    if (wr_timer) begin
      nxt_st.reload = reg_wdata;
      if (st_ff.state == tmr_pkg::TMR_IDLE) begin
        nxt_st.cnt = reg_wdata;
      end
    end

    unique case (st_ff.state)
      tmr_pkg::TMR_IDLE: begin
        if (start_ev) begin
          start_now = 1'b1;
        end
      end
      tmr_pkg::TMR_RUN: begin
        if (st_ff.cfg.mode == tmr_pkg::TMR_ONESHOT) begin
          if (start_ev) begin
            start_now = 1'b1;
          end else if (tick) begin
            if (st_ff.cnt <= 16'h0001) begin
              // reaching zero: reload, drop the pulse and halt
              nxt_st.cnt   = st_ff.reload;
              nxt_st.state = tmr_pkg::TMR_IDLE;
              nxt_st.pulse = 1'b0;
              event_set    = 1'b1;
            end else begin
              nxt_st.cnt = st_ff.cnt - 16'h0001;
            end
          end
        end else if (step) begin
          // triggers are not looked at here, so a running pwm ignores them
          if (st_ff.per == 16'h0000) begin
            nxt_st.cnt   = hi_val;
            nxt_st.pulse = hi_val != 16'h0000;
            if (st_ff.cfg.pwm8) begin
              nxt_st.per = tmr_pkg::PERIOD8_LAST;
            end else begin
              nxt_st.per = tmr_pkg::PERIOD16_LAST;
            end
            if (st_ff.pulse) begin
              event_set = hi_val == 16'h0000;
            end
          end else begin
            nxt_st.per = st_ff.per - 16'h0001;
            if (st_ff.cnt != 16'h0000) begin
              nxt_st.cnt = st_ff.cnt - 16'h0001;
              if (st_ff.cnt == 16'h0001) begin
                nxt_st.pulse = 1'b0;
                event_set    = 1'b1;
              end
            end
          end
        end
      end
    endcase

    if (start_now) begin
      nxt_st.state = tmr_pkg::TMR_RUN;
      // restart both dividers so the first step is a whole one
      nxt_st.pre   = 5'h00;
      nxt_st.sub   = 8'h00;
      // a value written in this same cycle is the one that is started
      if (st_ff.cfg.mode == tmr_pkg::TMR_ONESHOT) begin
        nxt_st.cnt   = start_val;
        nxt_st.pulse = start_val != 16'h0000;
      end else begin
        nxt_st.cnt   = pwm_high(st_ff.cfg.pwm8, start_val);
        nxt_st.pulse = nxt_st.cnt != 16'h0000;
        if (st_ff.cfg.pwm8) begin
          nxt_st.per = tmr_pkg::PERIOD8_LAST;
        end else begin
          nxt_st.per = tmr_pkg::PERIOD16_LAST;
        end
      end
    end

    // dropping the count start flag wins over any start or count step for state and pulse; an event of the same cycle still sets status
    if (wr_ctrl && !reg_wdata[tmr_pkg::CTRL_START]) begin
      nxt_st.state = tmr_pkg::TMR_IDLE;
      nxt_st.pulse = 1'b0;
    end

    // a new event beats the clear-on-read of the same cycle
    if (rd_status) begin
      nxt_st.status = 1'b0;
    end
    if (event_set) begin
      nxt_st.status = 1'b1;
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);

    // the pin is fed from the next state so it moves in the same cycle as the state
    // pwm always owns the pin; one-shot only when the pulse output is enabled
    if (nxt_st.cfg.mode == tmr_pkg::TMR_PWM) begin
      nxt_st.pin = nxt_st.pulse;
    end else if (nxt_st.cfg.pulse_en) begin
      nxt_st.pin = nxt_st.pulse;
    end else begin
      nxt_st.pin = nxt_st.port_val;
    end

    // read data stand for the one cycle after the strobe and are zero otherwise
    nxt_st.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        tmr_pkg::OFS_CTRL: begin
          nxt_st.rdata[tmr_pkg::CTRL_START] = st_ff.start;
          nxt_st.rdata[tmr_pkg::CTRL_RUN]   = st_ff.state == tmr_pkg::TMR_RUN;
        end
        tmr_pkg::OFS_MODE: begin
          nxt_st.rdata[tmr_pkg::CFG_W-1:0] = st_ff.cfg;
        end
        tmr_pkg::OFS_TIMER: begin
          // the live count is not offered; software must not use this value
          nxt_st.rdata = tmr_pkg::TIMER_RD_JUNK;
        end
        tmr_pkg::OFS_STATUS: begin
          nxt_st.rdata[tmr_pkg::ST_EVENT] = st_ff.status[0];
        end
        tmr_pkg::OFS_MASK: begin
          nxt_st.rdata[tmr_pkg::ST_EVENT] = st_ff.mask[0];
        end
        tmr_pkg::OFS_PORT: begin
          nxt_st.rdata[tmr_pkg::PORT_OUT_VAL] = st_ff.port_val;
          nxt_st.rdata[tmr_pkg::PORT_IN_LVL]  = trig_lvl;
        end
        default: begin
          nxt_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff        <= '0;
      st_ff.reload <= tmr_pkg::RST_RELOAD;
      st_ff.cnt    <= tmr_pkg::RST_RELOAD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata       = st_ff.rdata;
  assign timer_pulse_out = st_ff.pin;
  assign irq             = st_ff.irq;

endmodule
`default_nettype wire

// ### verilog/tmr_pkg.sv
// constants, types and register map of the one-shot / pwm timer channel
// assumes a plain register port with 4-bit word addresses and 16-bit data
package tmr_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;

  // register word addresses
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_MODE   = 4'h1;
  localparam logic [3:0] OFS_TIMER  = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_MASK   = 4'h4;
  localparam logic [3:0] OFS_PORT   = 4'h5;

  // control bits
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_OSSTART = 1;
  localparam int unsigned CTRL_RUN     = 2;

  // port register bits
  localparam int unsigned PORT_OUT_VAL = 0;
  localparam int unsigned PORT_IN_LVL  = 1;

  // status / mask bits
  localparam int unsigned ST_EVENT = 0;

  // what a timer read returns in these modes; software must not rely on it
  localparam logic [15:0] TIMER_RD_JUNK = 16'h0000;

  // prescaler terminal counts for the divided count sources
  localparam logic [4:0] DIV1_TC  = 5'h00;
  localparam logic [4:0] DIV8_TC  = 5'h07;
  localparam logic [4:0] DIV32_TC = 5'h1f;

  // pwm period counters run from these values down to zero
  localparam logic [15:0] PERIOD16_LAST = 16'hfffe;
  localparam logic [15:0] PERIOD8_LAST  = 16'h00fe;

  localparam logic [15:0] RST_RELOAD = 16'h0000;

  typedef enum logic [0:0] {
    TMR_ONESHOT = 1'b0,
    TMR_PWM     = 1'b1
  } tmr_mode_t;

  typedef enum logic [1:0] {
    TMR_CLK_F1  = 2'b00,
    TMR_CLK_F8  = 2'b01,
    TMR_CLK_F32 = 2'b10,
    TMR_CLK_RSV = 2'b11
  } tmr_clk_t;

  typedef enum logic [1:0] {
    TMR_TRIG_SW   = 2'b00,
    TMR_TRIG_FALL = 2'b01,
    TMR_TRIG_RISE = 2'b10,
    TMR_TRIG_OVF  = 2'b11
  } tmr_trig_t;

  typedef enum logic [0:0] {
    TMR_IDLE = 1'b0,
    TMR_RUN  = 1'b1
  } tmr_state_t;

  // mode register layout, low bit first: mode, pwm8, clk, trig, pulse_en
  typedef struct packed {
    logic      pulse_en;
    tmr_trig_t trig;
    tmr_clk_t  clk;
    logic      pwm8;
    tmr_mode_t mode;
  } tmr_cfg_t;

  localparam int unsigned CFG_W = 7;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tmr_req_t;

endpackage

// ### verilog/tmr_sync.sv
// three-stage synchroniser with agreement filter and edge pulses
// assumes din is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module tmr_sync (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } tmr_sync_st_t;

  tmr_sync_st_t st_ff;
  tmr_sync_st_t nxt_st;

  // s1 is only ever read by s2; the filter looks at s2 and s3
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = din;
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.rise = 1'b0;
    nxt_st.fall = 1'b0;
    if (st_ff.s2 == st_ff.s3 && st_ff.s3 != st_ff.lvl) begin
      nxt_st.lvl  = st_ff.s3;
      nxt_st.rise = st_ff.s3;
      nxt_st.fall = ~st_ff.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.lvl;
  assign rise  = st_ff.rise;
  assign fall  = st_ff.fall;

endmodule
`default_nettype wire

// ### verif/tmr_chk_sva.sv
// port checker for tmr_chan
// assumes MODE is only written while the channel is stopped
`timescale 1ns/1ps
`default_nettype none
module tmr_chk_sva (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        timer_pulse_out,
  input wire logic        irq
);
  logic        mask_ff;
  logic        port_ff;
  logic [6:0]  cfg_ff;
  logic [15:0] rld_ff;
  // shadows of written registers; the ports alone do not show the setup
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= 1'b0;
      port_ff <= 1'b0;
      cfg_ff  <= 7'h00;
      rld_ff  <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == tmr_pkg::OFS_MASK) mask_ff <= reg_wdata[0];
      if (reg_addr == tmr_pkg::OFS_PORT) port_ff <= reg_wdata[0];
      if (reg_addr == tmr_pkg::OFS_MODE) cfg_ff <= reg_wdata[6:0];
      if (reg_addr == tmr_pkg::OFS_TIMER) rld_ff <= reg_wdata;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_os_start;
    reg_wr && reg_addr == tmr_pkg::OFS_CTRL && reg_wdata[1:0] == 2'b11 && !timer_pulse_out
      && cfg_ff == 7'h40 && rld_ff == 16'h0003;
  endsequence
  sequence s_os_pulse;
    timer_pulse_out [*3] ##1 !timer_pulse_out;
  endsequence

  a_rdata_quiet:
    assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data outside read");
  a_timer_junk:
    assert property (reg_rd && reg_addr == tmr_pkg::OFS_TIMER |=>
      reg_rdata == tmr_pkg::TIMER_RD_JUNK) else $error("timer read not junk value");
  a_unmapped_rd:
    assert property (reg_rd && reg_addr > tmr_pkg::OFS_PORT |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
  a_stop_drops:
    assert property (reg_wr && reg_addr == tmr_pkg::OFS_CTRL && !reg_wdata[0] && !port_ff
      |=> !timer_pulse_out [*2]) else $error("pulse stayed after stop");
  a_fall_irq:
    assert property ($fell(timer_pulse_out) && !$past(reg_wr) && mask_ff |-> irq)
      else $error("no interrupt at pulse end");
  a_mask_gates:
    assert property (!mask_ff && !$past(mask_ff) |-> !irq) else $error("masked irq high");
  a_status_read:
    assert property (reg_rd && reg_addr == tmr_pkg::OFS_STATUS && irq && mask_ff
      |=> reg_rdata[tmr_pkg::ST_EVENT]) else $error("status bit missing");
  a_port_pin:
    assert property (reg_wr && reg_addr == tmr_pkg::OFS_PORT && !cfg_ff[6] && !cfg_ff[0]
      |=> timer_pulse_out == $past(reg_wdata[0])) else $error("port value not on pin");
  a_os_width:
    assert property (s_os_start |=> s_os_pulse) else $error("one-shot width wrong");
endmodule
bind tmr_chan tmr_chk_sva i_tmr_chk_sva (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .timer_pulse_out, .irq);
`default_nettype wire

// ### verif/tmr_far.sv
// far side: trigger source and a load that times the pulse pin
// assumes the pin is a registered output on sys_clk
`timescale 1ns/1ps
`default_nettype none
module tmr_far (
  input  wire logic   sys_clk,
  input  wire logic   trig_lvl,
  input  wire logic   pin,
  output logic        timer_trigger_in,
  output logic [31:0] hi_len,
  output logic [31:0] per_len
);
  logic [31:0] hi_run = 32'h0;
  logic [31:0] since  = 32'h0;
  logic        last   = 1'b0;
  assign timer_trigger_in = trig_lvl;
  // high time is latched at the fall, period from rise to rise
  always @(posedge sys_clk) begin
    if (pin && !last) begin
      per_len <= since;
      since   <= 32'h1;
    end else since <= since + 32'h1;
    if (pin) hi_run <= hi_run + 32'h1;
    else if (last) begin
      hi_len <= hi_run;
      hi_run <= 32'h0;
    end
    last <= pin;
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for tmr_chan: register tasks and pin timing
// assumes tmr_far drives the trigger pin and times the pulse pin
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        trig_lvl;
  logic        timer_trigger_in;
  logic        other_timer_ovf;
  logic        timer_pulse_out;
  logic        irq;
  logic [31:0] hi_len;
  logic [31:0] per_len;
  int          num_errors;
  int          checks_done;

  tmr_chan i_tmr_chan (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_trigger_in, .other_timer_ovf, .timer_pulse_out, .irq);
  tmr_far i_tmr_far (.sys_clk, .trig_lvl, .pin(timer_pulse_out), .timer_trigger_in, .hi_len,
    .per_len);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic tally(input logic ok, input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    tally(g === e, 32'(g), 32'(e));
  endtask
  task automatic chk_len(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, g, e);
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tally(g === e, 32'(g), 32'(e));
  endtask

  // one strobe cycle then a quiet one, so no strobe is set twice in a step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk_reg(d, e);
    @(posedge sys_clk);
  endtask
  task automatic wait_pin(input logic v, input int lim);
    int i;
    i = 0;
    #1;
    while (timer_pulse_out !== v && i < lim) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk_bit(timer_pulse_out, v);
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse_ovf();
    other_timer_ovf <= 1'b1;
    @(posedge sys_clk);
    other_timer_ovf <= 1'b0;
  endtask
  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {trig_lvl, other_timer_ovf, num_errors, checks_done} = '0;
    resetn = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd_chk(tmr_pkg::OFS_CTRL, 16'h0000);
    rd_chk(tmr_pkg::OFS_MODE, 16'h0000);
    rd_chk(4'hf, 16'h0000);
    wr(tmr_pkg::OFS_TIMER, 16'h0003);
    rd_chk(tmr_pkg::OFS_TIMER, tmr_pkg::TIMER_RD_JUNK);
    wr(tmr_pkg::OFS_MASK, 16'h0001);
    wr(tmr_pkg::OFS_MODE, 16'h0040);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    wait_pin(0, 20);
    settle();
    chk_len(hi_len, 32'd3);
    chk_bit(irq, 1'b1);
    rd_chk(tmr_pkg::OFS_STATUS, 16'h0001);
    #1 chk_bit(irq, 1'b0);
    wr(tmr_pkg::OFS_TIMER, 16'h0008);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    wait_pin(0, 30);
    settle();
    chk_len(hi_len, 32'd10);
    wr(tmr_pkg::OFS_TIMER, 16'h0004);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    wr(tmr_pkg::OFS_TIMER, 16'h0005);
    wait_pin(0, 20);
    settle();
    chk_len(hi_len, 32'd4);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    wait_pin(0, 20);
    settle();
    chk_len(hi_len, 32'd5);
    end_test("oneshot");
    wr(tmr_pkg::OFS_TIMER, 16'h0064);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    repeat (5) @(posedge sys_clk);
    wr(tmr_pkg::OFS_CTRL, 16'h0000);
    #1 chk_bit(timer_pulse_out, 1'b0);
    rd_chk(tmr_pkg::OFS_CTRL, 16'h0000);
    wr(tmr_pkg::OFS_MASK, 16'h0000);
    wr(tmr_pkg::OFS_MODE, 16'h0000);
    wr(tmr_pkg::OFS_PORT, 16'h0001);
    #1 chk_bit(timer_pulse_out, 1'b1);
    wr(tmr_pkg::OFS_PORT, 16'h0000);
    wr(tmr_pkg::OFS_TIMER, 16'h0003);
    wr(tmr_pkg::OFS_CTRL, 16'h0003);
    settle();
    settle();
    chk_bit(timer_pulse_out, 1'b0);
    chk_bit(irq, 1'b0);
    rd_chk(tmr_pkg::OFS_STATUS, 16'h0001);
    wr(tmr_pkg::OFS_MASK, 16'h0001);
    end_test("stop_port");
    wr(tmr_pkg::OFS_MODE, 16'h0060);
    wr(tmr_pkg::OFS_CTRL, 16'h0001);
    trig_lvl <= 1'b1;
    wait_pin(1, 20);
    wait_pin(0, 20);
    settle();
    chk_len(hi_len, 32'd3);
    rd_chk(tmr_pkg::OFS_PORT, 16'h0002);
    trig_lvl <= 1'b0;
    wr(tmr_pkg::OFS_MODE, 16'h0070);
    wr(tmr_pkg::OFS_CTRL, 16'h0001);
    pulse_ovf();
    wait_pin(1, 5);
    wait_pin(0, 20);
    end_test("triggers");
    wr(tmr_pkg::OFS_CTRL, 16'h0000);
    wr(tmr_pkg::OFS_MODE, 16'h0001);
    wr(tmr_pkg::OFS_TIMER, 16'h000a);
    wr(tmr_pkg::OFS_CTRL, 16'h0001);
    wait_pin(1, 5);
    wait_pin(0, 20);
    settle();
    chk_len(hi_len, 32'd10);
    chk_bit(irq, 1'b1);
    rd_chk(tmr_pkg::OFS_STATUS, 16'h0001);
    wait_pin(1, 70000);
    settle();
    chk_len(per_len, 32'd65535);
    wr(tmr_pkg::OFS_CTRL, 16'h0000);
    #1 chk_bit(timer_pulse_out, 1'b0);
    end_test("pwm16");
    wr(tmr_pkg::OFS_MODE, 16'h0033);
    wr(tmr_pkg::OFS_TIMER, 16'h0401);
    wr(tmr_pkg::OFS_CTRL, 16'h0001);
    settle();
    chk_bit(timer_pulse_out, 1'b0);
    pulse_ovf();
    wait_pin(1, 5);
    wait_pin(0, 40);
    settle();
    chk_len(hi_len, 32'd8);
    pulse_ovf();
    wait_pin(1, 600);
    settle();
    chk_len(per_len, 32'd510);
    end_test("pwm8");
    report_and_stop();
  end
endmodule
`default_nettype wire
